// ==== core/alu_ops_pkg.sv ====
// Package of operation codes, widths and reset values for the ALU datapath
`default_nettype none
package alu_ops_pkg;
  localparam int unsigned DATA_W = 8;                 // Data path width
  localparam int unsigned FADDR_W = 5;                // File address width
  localparam logic [4:0] FADDR_MAX = 5'h1f;           // Highest file address
  localparam logic [2:0] DIR_PORT_SEL = 3'h6;         // Operand of direction load
  localparam logic [7:0] ACC_RST = 8'h00;             // Accumulator reset value
  localparam logic [7:0] DIR_RST = 8'hff;             // Direction reset: all inputs
  localparam logic FLAG_RST = 1'b0;                   // Status flag reset value
  localparam int unsigned NIB_LO = 0;                 // Low nibble lowest bit
  localparam int unsigned NIB_HI = 4;                 // High nibble lowest bit

  // Operation select from the instruction decoder
  typedef enum logic [2:0] {
    OP_NONE,
    OP_ROT_LEFT,
    OP_ROT_RIGHT,
    OP_SUB,
    OP_SWAP,
    OP_DIR_LOAD,
    OP_XOR_IMM,
    OP_XOR_FILE
  } op_t;
endpackage
`default_nettype wire

// ==== core/alu_res_if.sv ====
// Interface carrying a computed result and its flag updates
`default_nettype none
interface alu_res_if;
  logic [7:0] result;   // Computed 8-bit result
  logic       c_new;    // New carry value
  logic       dc_new;   // New digit carry value
  logic       z_new;    // New zero value
  logic       c_we;     // Carry is updated
  logic       dc_we;    // Digit carry is updated
  logic       z_we;     // Zero is updated
  logic       has_res;  // Result is routed to a destination
  modport src (output result, c_new, dc_new, z_new, c_we, dc_we, z_we, has_res);
  modport dst (input result, c_new, dc_new, z_new, c_we, dc_we, z_we, has_res);
endinterface
`default_nettype wire

// ==== core/alu_compute.sv ====
// Combinational compute unit for rotate, subtract, swap and xor
`default_nettype none
module alu_compute (
  input  wire alu_ops_pkg::op_t op,        // Operation select
  input  wire logic [7:0]       acc,       // Accumulator value
  input  wire logic [7:0]       fval,      // File operand
  input  wire logic [7:0]       imm,       // Immediate literal
  input  wire logic             c_old,     // Current carry
  alu_res_if.src                res        // Result and flags
);
  // Zero detect, shared by several ops
  function automatic logic is_zero(input logic [7:0] v);
    return (v == 8'h00);
  endfunction

  wire [8:0] sub_full = {1'b0, fval} + {1'b0, ~acc} + 9'h001;   // f - W, two's compl.
  wire [4:0] sub_lo   = {1'b0, fval[3:0]} + {1'b0, ~acc[3:0]} + 5'h01;
  wire [7:0] rl_val   = {fval[6:0], c_old};
  wire [7:0] rr_val   = {c_old, fval[7:1]};
  wire [7:0] sw_val   = {fval[alu_ops_pkg::NIB_LO +: 4], fval[alu_ops_pkg::NIB_HI +: 4]};
  wire [7:0] xi_val   = acc ^ imm;
  wire [7:0] xf_val   = acc ^ fval;

  // Per-op result and flag enable selection
  always_comb begin
    res.result  = 8'h00;
    res.c_new   = c_old;
    res.dc_new  = 1'b0;
    res.z_new   = 1'b0;
    res.c_we    = 1'b0;
    res.dc_we   = 1'b0;
    res.z_we    = 1'b0;
    res.has_res = 1'b0;
    case (op)
      alu_ops_pkg::OP_ROT_LEFT: begin
        res.result = rl_val;
        res.c_new = fval[7];
        res.c_we = 1'b1;
        res.has_res = 1'b1;
      end
      alu_ops_pkg::OP_ROT_RIGHT: begin
        res.result = rr_val;
        res.c_new = fval[0];
        res.c_we = 1'b1;
        res.has_res = 1'b1;
      end
      alu_ops_pkg::OP_SUB: begin
        res.result = sub_full[7:0];
        res.c_new = sub_full[8];
        res.dc_new = sub_lo[4];
        res.z_new = is_zero(sub_full[7:0]);
        res.c_we = 1'b1;
        res.dc_we = 1'b1;
        res.z_we = 1'b1;
        res.has_res = 1'b1;
      end
      alu_ops_pkg::OP_SWAP: begin
        res.result = sw_val;
        res.has_res = 1'b1;
      end
      alu_ops_pkg::OP_XOR_IMM: begin
        res.result = xi_val;
        res.z_new = is_zero(xi_val);
        res.z_we = 1'b1;
        res.has_res = 1'b1;
      end
      alu_ops_pkg::OP_XOR_FILE: begin
        res.result = xf_val;
        res.z_new = is_zero(xf_val);
        res.z_we = 1'b1;
        res.has_res = 1'b1;
      end
      default: begin
        res.has_res = 1'b0;             // No-op and direction load compute nothing
      end
    endcase
  end
endmodule
`default_nettype wire

// ==== core/alu_flags.sv ====
// Status flag register holding carry, digit carry and zero
`default_nettype none
module alu_flags (
  input  wire logic clk,      // Core clock
  input  wire logic resetn,   // Synchronous reset, active low
  input  wire logic exec,     // Instruction executes this cycle
  alu_res_if.dst    res,      // Flag updates
  output logic      c_ff,     // Carry flag
  output logic      dc_ff,    // Digit carry flag
  output logic      z_ff      // Zero flag
);
  // Gated next values; flags not written by the op hold
  wire nxt_c  = (exec && res.c_we)  ? res.c_new  : c_ff;
  wire nxt_dc = (exec && res.dc_we) ? res.dc_new : dc_ff;
  wire nxt_z  = (exec && res.z_we)  ? res.z_new  : z_ff;

  // Flag storage
  always_ff @(posedge clk) begin
    if (!resetn) begin
      c_ff  <= alu_ops_pkg::FLAG_RST;
      dc_ff <= alu_ops_pkg::FLAG_RST;
      z_ff  <= alu_ops_pkg::FLAG_RST;
    end else begin
      c_ff  <= nxt_c;
      dc_ff <= nxt_dc;
      z_ff  <= nxt_z;
    end
  end
endmodule
`default_nettype wire

// ==== core/rotate_subtract_xor_alu_ops.sv ====
// Top of the execution datapath for rotate, subtract, swap, xor and direction load
// Operation
// - Rotate left: carry in bit0, bit7 out
// - Rotate right: carry in bit7, bit0 out
// - Destination bit: 0 accumulator, 1 file
// - Subtract accumulator from file, flags C DC Z
// - Swap nibbles, no flags change
// - Direction load copies accumulator, operand 6
// - Xor immediate into accumulator, zero only
// - Xor accumulator with file, zero only
`default_nettype none
module rotate_subtract_xor_alu_ops (
  input  wire logic             clk,        // Core instruction clock
  input  wire logic             resetn,     // Synchronous reset, active low
  input  wire logic             exec,       // Instruction valid this cycle
  input  wire alu_ops_pkg::op_t op,         // Decoded operation
  input  wire logic [4:0]       faddr,      // File address 0..31
  input  wire logic             dest_sel,   // 0 accumulator, 1 file
  input  wire logic [7:0]       imm,        // Immediate literal
  input  wire logic [2:0]       dir_sel,    // Direction load operand
  input  wire logic [7:0]       file_rdata, // File bank read data at faddr
  output logic [7:0]            file_wdata, // File bank write data
  output logic [4:0]            file_waddr, // File bank write address
  output logic                  file_we,    // File bank write, one cycle
  output logic [7:0]            acc_ff,     // Accumulator
  output logic [7:0]            dir_ff,     // Pin direction register
  output logic                  c_ff,       // Carry flag
  output logic                  dc_ff,      // Digit carry flag
  output logic                  z_ff        // Zero flag
);
  alu_res_if res_bus ();   // Compute to state path

  // Pure compute of result and flags
  alu_compute u_compute (
    .op    (op),
    .acc   (acc_ff),
    .fval  (file_rdata),
    .imm   (imm),
    .c_old (c_ff),
    .res   (res_bus.src)
  );

  // Flag storage with per-op write enables
  alu_flags u_flags (
    .clk    (clk),
    .resetn (resetn),
    .exec   (exec),
    .res    (res_bus.dst),
    .c_ff   (c_ff),
    .dc_ff  (dc_ff),
    .z_ff   (z_ff)
  );

  // Routing decode: immediate xor always lands in accumulator
  wire is_imm    = (op == alu_ops_pkg::OP_XOR_IMM);
  wire to_file   = exec && res_bus.has_res && dest_sel && !is_imm;
  wire to_acc    = exec && res_bus.has_res && (!dest_sel || is_imm);
  // Direction load only for the documented operand; others are ignored
  wire dir_load  = exec && (op == alu_ops_pkg::OP_DIR_LOAD) &&
                   (dir_sel == alu_ops_pkg::DIR_PORT_SEL);
  wire [7:0] nxt_acc = to_acc ? res_bus.result : acc_ff;
  wire [7:0] nxt_dir = dir_load ? acc_ff : dir_ff;

  // Accumulator and direction register
  always_ff @(posedge clk) begin
    if (!resetn) begin
      acc_ff <= alu_ops_pkg::ACC_RST;
      dir_ff <= alu_ops_pkg::DIR_RST;
    end else begin
      acc_ff <= nxt_acc;
      dir_ff <= nxt_dir;
    end
  end

  // Registered file write port; bank sees write one cycle after exec
  always_ff @(posedge clk) begin
    if (!resetn) begin
      file_we    <= 1'b0;
      file_wdata <= 8'h00;
      file_waddr <= 5'h00;
    end else begin
      file_we    <= to_file;
      file_wdata <= to_file ? res_bus.result : file_wdata;
      file_waddr <= to_file ? faddr : file_waddr;
    end
  end

  // Checks
  sequence s_exec_op(alu_ops_pkg::op_t o);
    exec && op == o;
  endsequence

  property p_rot_left;
    @(posedge clk) disable iff (!resetn)
    s_exec_op(alu_ops_pkg::OP_ROT_LEFT) ##0 !dest_sel |=>
      acc_ff == {$past(file_rdata[6:0]), $past(c_ff)} && c_ff == $past(file_rdata[7])
      && z_ff == $past(z_ff) && dc_ff == $past(dc_ff);
  endproperty
  a_rot_left: assert property (p_rot_left) else $error("rotate left wrong");

  property p_rot_right;
    @(posedge clk) disable iff (!resetn)
    s_exec_op(alu_ops_pkg::OP_ROT_RIGHT) |=>
      c_ff == $past(file_rdata[0]) && z_ff == $past(z_ff) && dc_ff == $past(dc_ff);
  endproperty
  a_rot_right: assert property (p_rot_right) else $error("rotate right wrong");

  property p_dest_file;
    @(posedge clk) disable iff (!resetn)
    exec && res_bus.has_res && dest_sel && !is_imm |=>
      file_we && file_waddr == $past(faddr) && acc_ff == $past(acc_ff);
  endproperty
  a_dest_file: assert property (p_dest_file) else $error("file routing wrong");

  property p_sub;
    @(posedge clk) disable iff (!resetn)
    s_exec_op(alu_ops_pkg::OP_SUB) ##0 !dest_sel |=>
      acc_ff == $past(file_rdata) - $past(acc_ff)
      && c_ff == ($past(file_rdata) >= $past(acc_ff))
      && dc_ff == ($past(file_rdata[3:0]) >= $past(acc_ff[3:0]));
  endproperty
  a_sub: assert property (p_sub) else $error("subtract wrong");

  property p_swap;
    @(posedge clk) disable iff (!resetn)
    s_exec_op(alu_ops_pkg::OP_SWAP) ##0 dest_sel |=>
      file_wdata == {$past(file_rdata[3:0]), $past(file_rdata[7:4])}
      && $stable(c_ff) && $stable(z_ff) && $stable(dc_ff);
  endproperty
  a_swap: assert property (p_swap) else $error("swap wrong");

  property p_dir;
    @(posedge clk) disable iff (!resetn)
    s_exec_op(alu_ops_pkg::OP_DIR_LOAD) ##0 dir_sel == alu_ops_pkg::DIR_PORT_SEL |=>
      dir_ff == $past(acc_ff) && $stable(c_ff) && $stable(z_ff);
  endproperty
  a_dir: assert property (p_dir) else $error("direction load wrong");

  property p_xor_imm;
    @(posedge clk) disable iff (!resetn)
    s_exec_op(alu_ops_pkg::OP_XOR_IMM) |=>
      acc_ff == ($past(acc_ff) ^ $past(imm)) && !file_we && c_ff == $past(c_ff);
  endproperty
  a_xor_imm: assert property (p_xor_imm) else $error("xor immediate wrong");

  property p_xor_file_zero;
    @(posedge clk) disable iff (!resetn)
    s_exec_op(alu_ops_pkg::OP_XOR_FILE) |=>
      z_ff == ($past(acc_ff) == $past(file_rdata)) && c_ff == $past(c_ff);
  endproperty
  a_xor_file_zero: assert property (p_xor_file_zero) else $error("xor zero wrong");

  property p_zero_sub;
    @(posedge clk) disable iff (!resetn)
    s_exec_op(alu_ops_pkg::OP_SUB) |=> z_ff == ($past(file_rdata) == $past(acc_ff));
  endproperty
  a_zero_sub: assert property (p_zero_sub) else $error("subtract zero wrong");

  // Shared steps for the routing and idle checks
  // An accumulator-bound result; the write port must stay low
  sequence s_acc_route;
    exec && res_bus.has_res && (!dest_sel || is_imm);
  endsequence

  // Every visible register holds and the bank sees no write
  sequence s_all_held;
    $stable(acc_ff) && $stable(dir_ff) && $stable(c_ff) && $stable(dc_ff) && $stable(z_ff)
    && !file_we;
  endsequence

  // Rotate right into the accumulator, old carry on top
  // Result path is not covered by the flag-only check above
  property p_rr_acc;
    @(posedge clk) disable iff (!resetn)
    s_exec_op(alu_ops_pkg::OP_ROT_RIGHT) ##0 !dest_sel |=>
      acc_ff == {$past(c_ff), $past(file_rdata[7:1])};
  endproperty
  a_rr_acc: assert property (p_rr_acc) else $error("rotate right data wrong");

  // Rotate left back into the file, accumulator untouched
  // Seen one edge late: the write port is registered
  property p_rl_file;
    @(posedge clk) disable iff (!resetn)
    s_exec_op(alu_ops_pkg::OP_ROT_LEFT) ##0 dest_sel |=>
      file_wdata == {$past(file_rdata[6:0]), $past(c_ff)} && acc_ff == $past(acc_ff);
  endproperty
  a_rl_file: assert property (p_rl_file) else $error("rotate left file wrong");

  // Subtract written back to the file keeps the accumulator
  // Result wraps to eight bits, as the hardware does
  property p_sub_file;
    @(posedge clk) disable iff (!resetn)
    s_exec_op(alu_ops_pkg::OP_SUB) ##0 dest_sel |=>
      file_wdata == $past(file_rdata) - $past(acc_ff) && $stable(acc_ff);
  endproperty
  a_sub_file: assert property (p_sub_file) else $error("subtract file wrong");

  // Borrow flags on the file path follow the same convention
  property p_sub_flags;
    @(posedge clk) disable iff (!resetn)
    s_exec_op(alu_ops_pkg::OP_SUB) ##0 dest_sel |=>
      c_ff == ($past(file_rdata) >= $past(acc_ff))
      && dc_ff == ($past(file_rdata[3:0]) >= $past(acc_ff[3:0]));
  endproperty
  a_sub_flags: assert property (p_sub_flags) else $error("subtract file flags wrong");

  // Swap into the accumulator, bank left alone
  // Nibble order is checked independently of the compute wiring
  property p_swap_acc;
    @(posedge clk) disable iff (!resetn)
    s_exec_op(alu_ops_pkg::OP_SWAP) ##0 !dest_sel |=>
      acc_ff == {$past(file_rdata[3:0]), $past(file_rdata[7:4])} && !file_we;
  endproperty
  a_swap_acc: assert property (p_swap_acc) else $error("swap to accumulator wrong");

  // Swap to the file lands at the addressed register only
  // A stray accumulator update here would corrupt the next op
  property p_swap_keep;
    @(posedge clk) disable iff (!resetn)
    s_exec_op(alu_ops_pkg::OP_SWAP) ##0 dest_sel |=>
      acc_ff == $past(acc_ff) && file_we && file_waddr == $past(faddr);
  endproperty
  a_swap_keep: assert property (p_swap_keep) else $error("swap routing wrong");

  // Register xor into the accumulator; digit carry holds
  property p_xf_acc;
    @(posedge clk) disable iff (!resetn)
    s_exec_op(alu_ops_pkg::OP_XOR_FILE) ##0 !dest_sel |=>
      acc_ff == ($past(acc_ff) ^ $past(file_rdata)) && dc_ff == $past(dc_ff);
  endproperty
  a_xf_acc: assert property (p_xf_acc) else $error("xor to accumulator wrong");

  // Register xor back into the file; accumulator holds
  property p_xf_file;
    @(posedge clk) disable iff (!resetn)
    s_exec_op(alu_ops_pkg::OP_XOR_FILE) ##0 dest_sel |=>
      file_wdata == ($past(acc_ff) ^ $past(file_rdata)) && $stable(acc_ff);
  endproperty
  a_xf_file: assert property (p_xf_file) else $error("xor to file wrong");

  // Literal xor: zero from the result, digit carry holds
  // Zero is set exactly when accumulator equals the literal
  property p_xi_zero;
    @(posedge clk) disable iff (!resetn)
    s_exec_op(alu_ops_pkg::OP_XOR_IMM) |=>
      z_ff == ($past(acc_ff) == $past(imm)) && dc_ff == $past(dc_ff);
  endproperty
  a_xi_zero: assert property (p_xi_zero) else $error("xor literal zero wrong");

  // Accumulator-bound results leave the write port idle
  property p_dest_acc;
    @(posedge clk) disable iff (!resetn)
    s_acc_route |=>
      !file_we && file_waddr == $past(file_waddr);
  endproperty
  a_dest_acc: assert property (p_dest_acc) else $error("accumulator routing wrong");

  // Write data and address hold between file writes
  // The bank may latch them late, so they must not wander
  property p_wr_hold;
    @(posedge clk) disable iff (!resetn)
    !(exec && res_bus.has_res && dest_sel && !is_imm) |=>
      $stable(file_wdata) && $stable(file_waddr);
  endproperty
  a_wr_hold: assert property (p_wr_hold) else $error("write port moved");

  // No strobe, no change anywhere
  // Holds whatever op pattern sits on the decoder inputs
  property p_idle;
    @(posedge clk) disable iff (!resetn)
    !exec |=>
      s_all_held;
  endproperty
  a_idle: assert property (p_idle) else $error("state moved while idle");

  // The empty op is refused like a missing strobe
  // Decoder may pulse exec with no op on a skipped slot
  property p_none_op;
    @(posedge clk) disable iff (!resetn)
    s_exec_op(alu_ops_pkg::OP_NONE) |=>
      s_all_held;
  endproperty
  a_none_op: assert property (p_none_op) else $error("empty op changed state");

  // Direction load with any other operand is ignored
  // Only one direction register exists in this block
  property p_dir_skip;
    @(posedge clk) disable iff (!resetn)
    s_exec_op(alu_ops_pkg::OP_DIR_LOAD) ##0 dir_sel != alu_ops_pkg::DIR_PORT_SEL |=>
      $stable(dir_ff);
  endproperty
  a_dir_skip: assert property (p_dir_skip) else $error("direction load not ignored");

  // Direction load touches neither flags, accumulator nor bank
  property p_dir_quiet;
    @(posedge clk) disable iff (!resetn)
    s_exec_op(alu_ops_pkg::OP_DIR_LOAD) |=>
      $stable(acc_ff) && $stable(c_ff) && $stable(dc_ff) && $stable(z_ff) && !file_we;
  endproperty
  a_dir_quiet: assert property (p_dir_quiet) else $error("direction load side effect");
endmodule
`default_nettype wire

// ==== sim/file_bank_model.sv ====
// Behavioural file register bank facing the datapath
`default_nettype none
module file_bank_model (
  input  wire logic       clk,        // Core clock
  input  wire logic [4:0] faddr,      // Read address
  output logic      [7:0] file_rdata, // Read data, combinational
  input  wire logic [7:0] file_wdata, // Write data
  input  wire logic [4:0] file_waddr, // Write address
  input  wire logic       file_we     // Write strobe
);
  logic [7:0] mem [32]; // Bank contents

  // Known preload: 8'h80 plus the address
  initial begin
    for (int i = 0; i < 32; i++) begin
      mem[i] = 8'h80 | 8'(i);
    end
  end

  // Read follows the address at once, as the decoder expects
  assign file_rdata = mem[faddr];

  // Write lands at the edge that shows the strobe
  always @(posedge clk) begin
    if (file_we === 1'b1) begin
      mem[file_waddr] <= file_wdata;
    end
  end
endmodule
`default_nettype wire

// ==== sim/rotate_subtract_xor_alu_ops_tb.sv ====
// Directed testbench of the rotate, subtract, swap, xor and direction datapath
`default_nettype none
module rotate_subtract_xor_alu_ops_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic             clk;        // Core clock
  logic             resetn;     // Reset, active low
  logic             exec;       // Execute strobe
  alu_ops_pkg::op_t op;         // Operation
  logic [4:0]       faddr;      // File address
  logic             dest_sel;   // Destination select
  logic [7:0]       imm;        // Literal
  logic [2:0]       dir_sel;    // Direction operand
  logic [7:0]       file_rdata; // Bank read data
  logic [7:0]       file_wdata; // Bank write data
  logic [4:0]       file_waddr; // Bank write address
  logic             file_we;    // Bank write strobe
  logic [7:0]       acc_ff;     // Accumulator
  logic [7:0]       dir_ff;     // Direction register
  logic             c_ff;       // Carry
  logic             dc_ff;      // Digit carry
  logic             z_ff;       // Zero
  int               error_cnt;  // Mismatches
  int               total_checks; // Comparisons

  rotate_subtract_xor_alu_ops u_rotate_subtract_xor_alu_ops (
    .clk(clk), .resetn(resetn), .exec(exec), .op(op), .faddr(faddr), .dest_sel(dest_sel),
    .imm(imm), .dir_sel(dir_sel), .file_rdata(file_rdata), .file_wdata(file_wdata),
    .file_waddr(file_waddr), .file_we(file_we), .acc_ff(acc_ff), .dir_ff(dir_ff),
    .c_ff(c_ff), .dc_ff(dc_ff), .z_ff(z_ff));

  file_bank_model u_file_bank_model (
    .clk(clk), .faddr(faddr), .file_rdata(file_rdata), .file_wdata(file_wdata),
    .file_waddr(file_waddr), .file_we(file_we));

  // Clock of 5 ns period
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  // Compare one value and count it
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    total_checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  // Verdict and end of run
  task automatic wrap_up();
    if (error_cnt == 0 && total_checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  // One executed op, then accumulator, flag and write port check one cycle later; ef is C, DC, Z, write
  task automatic run(input alu_ops_pkg::op_t o, input logic [4:0] fa, input logic d,
                     input logic [7:0] k, input logic [2:0] ds, input logic [7:0] ea,
                     input logic [3:0] ef, input logic [7:0] ewd);
    @(posedge clk);
    exec <= 1'b1;
    op <= o;
    faddr <= fa;
    dest_sel <= d;
    imm <= k;
    dir_sel <= ds;
    @(posedge clk);
    exec <= 1'b0;
    #1;
    chk(acc_ff, ea);
    chk({5'h00, c_ff, dc_ff, z_ff}, {5'h00, ef[3:1]});
    chk({7'h00, file_we}, {7'h00, ef[0]});
    if (ef[0]) begin
      chk({3'h0, file_waddr}, {3'h0, fa});
      chk(file_wdata, ewd);
    end
  endtask

  // Reset values at the ports
  task automatic t_reset();
    chk(acc_ff, 8'h00);
    chk(dir_ff, 8'hff);
    chk({4'h0, c_ff, dc_ff, z_ff, file_we}, 8'h00);
    chk(file_wdata, 8'h00);
    chk({3'h0, file_waddr}, 8'h00);
  endtask

  // Literal xor, destination bit ignored
  task automatic t_xor_imm();
    run(alu_ops_pkg::OP_XOR_IMM, 5'h00, 1'b1, 8'hff, 3'h0, 8'hff, 4'h0, 8'h00);
    run(alu_ops_pkg::OP_XOR_IMM, 5'h00, 1'b0, 8'hff, 3'h0, 8'h00, 4'h2, 8'h00);
  endtask

  // Rotations through carry, both carry values, zero held
  task automatic t_rotate();
    run(alu_ops_pkg::OP_ROT_LEFT, 5'h03, 1'b1, 8'h00, 3'h0, 8'h00, 4'hb, 8'h06);
    run(alu_ops_pkg::OP_ROT_RIGHT, 5'h03, 1'b0, 8'h00, 3'h0, 8'h83, 4'h2, 8'h00);
    run(alu_ops_pkg::OP_ROT_RIGHT, 5'h01, 1'b0, 8'h00, 3'h0, 8'h40, 4'ha, 8'h00);
    run(alu_ops_pkg::OP_ROT_LEFT, 5'h00, 1'b0, 8'h00, 3'h0, 8'h01, 4'ha, 8'h00);
  endtask

  // Subtract with borrow, nibble borrow and zero cases
  task automatic t_sub();
    run(alu_ops_pkg::OP_SUB, 5'h00, 1'b0, 8'h00, 3'h0, 8'h7f, 4'h8, 8'h00);
    run(alu_ops_pkg::OP_SUB, 5'h1f, 1'b1, 8'h00, 3'h0, 8'h7f, 4'hd, 8'h20);
    run(alu_ops_pkg::OP_XOR_IMM, 5'h00, 1'b0, 8'h80, 3'h0, 8'hff, 4'hc, 8'h00);
    run(alu_ops_pkg::OP_SUB, 5'h1f, 1'b0, 8'h00, 3'h0, 8'h21, 4'h0, 8'h00);
    run(alu_ops_pkg::OP_XOR_IMM, 5'h00, 1'b0, 8'ha4, 3'h0, 8'h85, 4'h0, 8'h00);
    run(alu_ops_pkg::OP_SUB, 5'h05, 1'b0, 8'h00, 3'h0, 8'h00, 4'he, 8'h00);
  endtask

  // Nibble swap to both destinations, flags kept
  task automatic t_swap();
    run(alu_ops_pkg::OP_SWAP, 5'h03, 1'b0, 8'h00, 3'h0, 8'h60, 4'he, 8'h00);
    run(alu_ops_pkg::OP_SWAP, 5'h03, 1'b1, 8'h00, 3'h0, 8'h60, 4'hf, 8'h60);
  endtask

  // Direction load: wrong operand ignored, operand 6 copies
  task automatic t_dir();
    run(alu_ops_pkg::OP_XOR_IMM, 5'h00, 1'b0, 8'h3a, 3'h0, 8'h5a, 4'hc, 8'h00);
    run(alu_ops_pkg::OP_DIR_LOAD, 5'h00, 1'b0, 8'h00, 3'h7, 8'h5a, 4'hc, 8'h00);
    chk(dir_ff, 8'hff);
    run(alu_ops_pkg::OP_DIR_LOAD, 5'h00, 1'b1, 8'h00, 3'h6, 8'h5a, 4'hc, 8'h00);
    chk(dir_ff, 8'h5a);
  endtask

  // File xor to both destinations, zero set and clear
  task automatic t_xor_file();
    run(alu_ops_pkg::OP_XOR_FILE, 5'h03, 1'b1, 8'h00, 3'h0, 8'h5a, 4'hd, 8'h3a);
    run(alu_ops_pkg::OP_XOR_IMM, 5'h00, 1'b0, 8'h60, 3'h0, 8'h3a, 4'hc, 8'h00);
    run(alu_ops_pkg::OP_XOR_FILE, 5'h03, 1'b0, 8'h00, 3'h0, 8'h00, 4'he, 8'h00);
  endtask

  // Idle op and missing strobe change nothing
  task automatic t_idle();
    run(alu_ops_pkg::OP_NONE, 5'h02, 1'b1, 8'hff, 3'h6, 8'h00, 4'he, 8'h00);
    @(posedge clk);
    op <= alu_ops_pkg::OP_XOR_IMM;
    repeat (2) @(posedge clk);
    #1;
    chk(acc_ff, 8'h00);
    chk({7'h00, file_we}, 8'h00);
  endtask

  // Main sequence: reset held 16 cycles
  initial begin
    error_cnt = 0;
    total_checks = 0;
    resetn = 1'b0;
    exec = 1'b0;
    op = alu_ops_pkg::OP_NONE;
    faddr = 5'h00;
    dest_sel = 1'b0;
    imm = 8'h00;
    dir_sel = 3'h0;
    repeat (16) @(posedge clk);
    resetn <= 1'b1;
    #1;
    t_reset();
    t_xor_imm();
    t_rotate();
    t_sub();
    t_swap();
    t_dir();
    t_xor_file();
    t_idle();
    wrap_up();
  end

  // Watchdog: tests need well under 200 cycles
  initial begin
    #20000;
    error_cnt++;
    wrap_up();
  end
endmodule
`default_nettype wire
